// File: src/obt_pkg.sv
// Summary of operation
// - each store clock rise captures its bus
// - capture never gated by enable or direction
// - never drive both buses at once
// - enable high leaves both buses undriven
// - toward a, live select drives live b
// - toward a, stored select drives b register
// - toward b, live select drives live a
// - toward b, stored select drives a register
// - build option inverts the driven data
// - idle and static clocks hold registers
package obt_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int          OBT_WIDTH          = 8;     // bus lines
  localparam logic        OBT_OE_RESET       = 1'h0;  // released
  localparam logic [7:0]  OBT_OUT_RESET      = 8'h00; // quiet data
  // previous store clock level after reset; high so a clock that
  // is already high at release does not look like a rising edge
  localparam logic        OBT_STORE_CLK_INIT = 1'h1;

  // ---------------------------------------------------------------
  // control encodings
  // ---------------------------------------------------------------
  localparam logic OBT_ENABLE_ACTIVE = 1'h0;  // drive enable is low
  localparam logic OBT_DIR_TO_A      = 1'h0;  // b side feeds a bus
  localparam logic OBT_DIR_TO_B      = 1'h1;  // a side feeds b bus
  localparam logic OBT_SEL_LIVE      = 1'h0;  // pass-through data
  localparam logic OBT_SEL_STORED    = 1'h1;  // register contents

  // ---------------------------------------------------------------
  // drive modes, gray along isolate -> a -> b
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    OBT_MODE_ISOLATE = 2'h0,
    OBT_MODE_DRIVE_A = 2'h1,
    OBT_MODE_DRIVE_B = 2'h3
  } obt_mode_type;

endpackage

// File: src/obt_store_reg.sv
`timescale 1ns/1ps
module obt_store_reg
  import obt_pkg::*;
#(
  parameter int WIDTH = OBT_WIDTH
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // store clock level and bus level
  input  wire logic             store_clock,
  input  wire logic [WIDTH-1:0] bus_level,
  // held contents
  output logic      [WIDTH-1:0] stored
);

  // ---------------------------------------------------------------
  // store clock edge detection
  // ---------------------------------------------------------------
  logic store_clock_prev;  // level seen one cycle earlier
  logic store_rise;        // low-to-high seen this cycle

  // inputs are synchronous to clk, so no synchroniser is needed
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      store_clock_prev <= OBT_STORE_CLK_INIT;
    else
      store_clock_prev <= store_clock;
  end

  assign store_rise = store_clock & ~store_clock_prev;

  // ---------------------------------------------------------------
  // storage, deliberately without reset
  // ---------------------------------------------------------------
  // pins are read whatever the drive mode, so a driven bus stores
  // the value the device itself puts out
  always_ff @(posedge clk)
  begin
    // no edge means no load, so both registers hold in every mode
    if (store_rise)
      stored <= bus_level;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  capture_on_edge_a: assert property (
    @(posedge clk) disable iff (reset)
    store_rise |=> stored == $past(bus_level))
    else $error("store edge did not capture bus");

  hold_no_edge_a: assert property (
    @(posedge clk) disable iff (reset)
    !store_rise |=> $stable(stored))
    else $error("register changed without store edge");

endmodule

// File: src/obt_transceiver.sv
`timescale 1ns/1ps
module obt_transceiver
  import obt_pkg::*;
#(
  parameter int WIDTH  = OBT_WIDTH,  // bus lines
  parameter bit INVERT = 1'b0        // inverting build variant
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // transfer control
  input  wire logic             drive_enable_n,
  input  wire logic             direction,
  input  wire logic             a_side_source_select,
  input  wire logic             b_side_source_select,
  // store clocks
  input  wire logic             a_to_b_store_clock,
  input  wire logic             b_to_a_store_clock,
  // a bus pin
  input  wire logic [WIDTH-1:0] a_bus_in,
  output logic      [WIDTH-1:0] a_bus_out,
  output logic                  a_bus_oe,
  // b bus pin
  input  wire logic [WIDTH-1:0] b_bus_in,
  output logic      [WIDTH-1:0] b_bus_out,
  output logic                  b_bus_oe
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam logic [WIDTH-1:0] INV_MASK = {WIDTH{INVERT}};

  logic [WIDTH-1:0] a_store;     // a bus contents
  logic [WIDTH-1:0] b_store;     // b bus contents
  obt_mode_type     next_mode;   // drive mode from controls
  logic [WIDTH-1:0] next_a_out;  // data toward the a bus
  logic [WIDTH-1:0] next_b_out;  // data toward the b bus

  // ---------------------------------------------------------------
  // storage registers
  // ---------------------------------------------------------------
  // a side register watches the a pins on its own store clock
  obt_store_reg #(
    .WIDTH       (WIDTH)
  ) u_a_store (
    .clk         (clk),
    .reset       (reset),
    .store_clock (a_to_b_store_clock),
    .bus_level   (a_bus_in),
    .stored      (a_store)
  );

  // b side register watches the b pins on its own store clock
  obt_store_reg #(
    .WIDTH       (WIDTH)
  ) u_b_store (
    .clk         (clk),
    .reset       (reset),
    .store_clock (b_to_a_store_clock),
    .bus_level   (b_bus_in),
    .stored      (b_store)
  );

  // ---------------------------------------------------------------
  // drive mode decode
  // ---------------------------------------------------------------
  // one mode at a time, so both enables can never be high together
  always_comb
  begin
    if (drive_enable_n != OBT_ENABLE_ACTIVE)
      next_mode = OBT_MODE_ISOLATE;
    else if (direction == OBT_DIR_TO_B)
      next_mode = OBT_MODE_DRIVE_B;
    else
      next_mode = OBT_MODE_DRIVE_A;
  end

  // ---------------------------------------------------------------
  // data source select
  // ---------------------------------------------------------------
  // inversion is applied in each branch of the select, so live and stored
  // data are treated alike
  always_comb
  begin
    if (a_side_source_select == OBT_SEL_STORED)
      next_a_out = b_store ^ INV_MASK;
    else
      next_a_out = b_bus_in ^ INV_MASK;
    if (b_side_source_select == OBT_SEL_STORED)
      next_b_out = a_store ^ INV_MASK;
    else
      next_b_out = a_bus_in ^ INV_MASK;
  end

  // ---------------------------------------------------------------
  // a bus output flops
  // ---------------------------------------------------------------
  // registered outputs add one clk of latency; the trade buys
  // glitch-free enables on the pin
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      a_bus_oe  <= OBT_OE_RESET;
      a_bus_out <= WIDTH'(OBT_OUT_RESET);
    end
    else
    begin
      a_bus_oe  <= (next_mode == OBT_MODE_DRIVE_A);
      a_bus_out <= next_a_out;
    end
  end

  // ---------------------------------------------------------------
  // b bus output flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      b_bus_oe  <= OBT_OE_RESET;
      b_bus_out <= WIDTH'(OBT_OUT_RESET);
    end
    else
    begin
      b_bus_oe  <= (next_mode == OBT_MODE_DRIVE_B);
      b_bus_out <= next_b_out;
    end
  end

  // attached logic must release whichever bus has its enable high;
  // contention there is not detected here

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // outputs are registered, so every check but one_side_a looks one edge past
  // the controls that chose them; $past lines the data up again
  one_side_a: assert property (
    @(posedge clk) disable iff (reset)
    !(a_bus_oe && b_bus_oe))
    else $error("both buses driven");

  isolate_both_a: assert property (
    @(posedge clk) disable iff (reset)
    (drive_enable_n != OBT_ENABLE_ACTIVE) |=> !a_bus_oe && !b_bus_oe)
    else $error("bus driven while enable inactive");

  live_b_to_a_a: assert property (
    @(posedge clk) disable iff (reset)
    (drive_enable_n == OBT_ENABLE_ACTIVE && direction == OBT_DIR_TO_A
     && a_side_source_select == OBT_SEL_LIVE)
    |=> a_bus_oe && !b_bus_oe
        && a_bus_out == ($past(b_bus_in) ^ INV_MASK))
    else $error("a bus not fed from live b");

  stored_b_to_a_a: assert property (
    @(posedge clk) disable iff (reset)
    (drive_enable_n == OBT_ENABLE_ACTIVE && direction == OBT_DIR_TO_A
     && a_side_source_select == OBT_SEL_STORED)
    |=> a_bus_oe && !b_bus_oe
        && a_bus_out == ($past(b_store) ^ INV_MASK))
    else $error("a bus not fed from b register");

  live_a_to_b_a: assert property (
    @(posedge clk) disable iff (reset)
    (drive_enable_n == OBT_ENABLE_ACTIVE && direction == OBT_DIR_TO_B
     && b_side_source_select == OBT_SEL_LIVE)
    |=> b_bus_oe && !a_bus_oe
        && b_bus_out == ($past(a_bus_in) ^ INV_MASK))
    else $error("b bus not fed from live a");

  stored_a_to_b_a: assert property (
    @(posedge clk) disable iff (reset)
    (drive_enable_n == OBT_ENABLE_ACTIVE && direction == OBT_DIR_TO_B
     && b_side_source_select == OBT_SEL_STORED)
    |=> b_bus_oe && !a_bus_oe
        && b_bus_out == ($past(a_store) ^ INV_MASK))
    else $error("b bus not fed from a register");

  invert_variant_a: assert property (
    @(posedge clk) disable iff (reset)
    (b_side_source_select == OBT_SEL_LIVE)
    |=> (b_bus_out ^ $past(a_bus_in)) == INV_MASK)
    else $error("inversion does not match variant");

  // the a side path has its own xor, so it is checked on its own
  invert_toward_a_a: assert property (
    @(posedge clk) disable iff (reset)
    (a_side_source_select == OBT_SEL_LIVE)
    |=> (a_bus_out ^ $past(b_bus_in)) == INV_MASK)
    else $error("a side inversion does not match variant");

  isolate_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    (drive_enable_n != OBT_ENABLE_ACTIVE
     && $stable(a_to_b_store_clock) && $stable(b_to_a_store_clock))
    |=> $stable(a_store) && $stable(b_store)
        && !a_bus_oe && !b_bus_oe)
    else $error("isolation did not hold storage");

  // main scenarios
  drive_a_stored_c: cover property (
    @(posedge clk) disable iff (reset)
    a_bus_oe && $past(a_side_source_select == OBT_SEL_STORED));

  drive_b_live_c: cover property (
    @(posedge clk) disable iff (reset)
    b_bus_oe && $past(b_side_source_select == OBT_SEL_LIVE));

  both_store_isolated_c: cover property (
    @(posedge clk) disable iff (reset)
    drive_enable_n && $rose(a_to_b_store_clock)
    && $rose(b_to_a_store_clock));

  turnaround_c: cover property (
    @(posedge clk) disable iff (reset)
    a_bus_oe ##1 !a_bus_oe && !b_bus_oe ##1 b_bus_oe);

  // storing the bus that the device itself is driving
  stored_while_driven_c: cover property (
    @(posedge clk) disable iff (reset)
    b_bus_oe && $rose(b_to_a_store_clock));

endmodule

// File: tb/obt_bus_partner.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// attached logic on both buses, resolves each wire
// ---------------------------------------------------------------
module obt_bus_partner
  import obt_pkg::*;
(
  // levels the attached logic wants to put on the wires
  input  wire logic [7:0] a_value,
  input  wire logic [7:0] b_value,
  // device pins
  input  wire logic [7:0] a_bus_out,
  input  wire logic       a_bus_oe,
  input  wire logic [7:0] b_bus_out,
  input  wire logic       b_bus_oe,
  // resolved wire levels
  output logic      [7:0] a_bus_in,
  output logic      [7:0] b_bus_in
);
  // let go while the device drives, so no contention can occur
  assign a_bus_in = a_bus_oe ? a_bus_out : a_value;
  assign b_bus_in = b_bus_oe ? b_bus_out : b_value;
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import obt_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed wires
  // ---------------------------------------------------------------
  logic       clk = 1'b0;    // 25 MHz
  logic       reset = 1'b1;  // held 3 cycles
  logic       en_n = 1'b1;   // drive enable
  logic       dir = 1'b0;    // direction
  logic       asel = 1'b0;   // a side source select
  logic       bsel = 1'b0;   // b side source select
  logic       ca = 1'b0;     // a to b store clock
  logic       cb = 1'b0;     // b to a store clock
  logic [7:0] av = 8'h00;    // attached logic on a
  logic [7:0] bv = 8'h00;    // attached logic on b
  logic [7:0] a_in, b_in, a_out, b_out, ia_out, ib_out;
  logic       a_oe, b_oe, ia_oe, ib_oe;
  int         errors = 0;
  int         check_count = 0;
  // clock, inverted each half period
  always #20 clk = ~clk;
  obt_transceiver dut (.clk(clk), .reset(reset), .drive_enable_n(en_n),
    .direction(dir), .a_side_source_select(asel),
    .b_side_source_select(bsel), .a_to_b_store_clock(ca),
    .b_to_a_store_clock(cb), .a_bus_in(a_in), .a_bus_out(a_out),
    .a_bus_oe(a_oe), .b_bus_in(b_in), .b_bus_out(b_out), .b_bus_oe(b_oe));
  // inverting build watches the same wires; its outputs are only checked and do not drive the wires
  obt_transceiver #(.INVERT(1'b1)) dut_inv (.clk(clk), .reset(reset),
    .drive_enable_n(en_n), .direction(dir), .a_side_source_select(asel),
    .b_side_source_select(bsel), .a_to_b_store_clock(ca),
    .b_to_a_store_clock(cb), .a_bus_in(a_in), .a_bus_out(ia_out),
    .a_bus_oe(ia_oe), .b_bus_in(b_in), .b_bus_out(ib_out),
    .b_bus_oe(ib_oe));
  obt_bus_partner partner (.a_value(av), .b_value(bv), .a_bus_out(a_out),
    .a_bus_oe(a_oe), .b_bus_out(b_out), .b_bus_oe(b_oe),
    .a_bus_in(a_in), .b_bus_in(b_in));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task close_out;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // both enables, then the driven data of both builds
  task drive_check(input logic ea, input logic eb, input logic [7:0] d);
    cmp("a_bus_oe", {7'h00, ea}, {7'h00, a_oe});
    cmp("b_bus_oe", {7'h00, eb}, {7'h00, b_oe});
    cmp("inv a_bus_oe", {7'h00, ea}, {7'h00, ia_oe});
    cmp("inv b_bus_oe", {7'h00, eb}, {7'h00, ib_oe});
    if (ea || eb)
    begin
      cmp("driven", d, eb ? b_out : a_out);
      cmp("inverted", ~d, eb ? ib_out : ia_out);
    end
  endtask
  // controls and attached levels, outputs settle two edges on
  task apply(input logic e, input logic d, input logic s_a, input logic s_b,
             input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    en_n <= e;
    dir  <= d;
    asel <= s_a;
    bsel <= s_b;
    av   <= a;
    bv   <= b;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // one store clock pulse, high for one cycle, then low
  task store(input logic sa, input logic sb);
    @(posedge clk);
    ca <= sa;
    cb <= sb;
    @(posedge clk);
    ca <= 1'b0;
    cb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    @(posedge clk);
    #1;
    drive_check(1'b0, 1'b0, 8'h00);
    cmp("a_bus_out", 8'h00, a_out);
    cmp("b_bus_out", 8'h00, b_out);
  endtask
  task t_live;
    apply(1'b0, 1'b1, 1'b0, 1'b0, 8'h5a, 8'h00);
    drive_check(1'b0, 1'b1, 8'h5a);
    apply(1'b0, 1'b1, 1'b0, 1'b0, 8'ha6, 8'h00);
    drive_check(1'b0, 1'b1, 8'ha6);
    apply(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h71);
    drive_check(1'b1, 1'b0, 8'h71);
  endtask
  task t_store;
    apply(1'b1, 1'b0, 1'b0, 1'b0, 8'h3c, 8'hc3);
    drive_check(1'b0, 1'b0, 8'h00);
    store(1'b1, 1'b1);
    apply(1'b0, 1'b1, 1'b0, 1'b1, 8'he1, 8'hc3);
    drive_check(1'b0, 1'b1, 8'h3c);
    apply(1'b0, 1'b0, 1'b1, 1'b0, 8'h3c, 8'h2d);
    drive_check(1'b1, 1'b0, 8'hc3);
  endtask
  // b is stored while the device itself drives it
  task t_gate;
    apply(1'b0, 1'b1, 1'b0, 1'b1, 8'h55, 8'h00);
    store(1'b0, 1'b1);
    apply(1'b0, 1'b0, 1'b1, 1'b0, 8'h55, 8'h00);
    drive_check(1'b1, 1'b0, 8'h3c);
  endtask
  task t_hold;
    apply(1'b1, 1'b0, 1'b0, 1'b0, 8'h99, 8'h66);
    repeat (4) @(posedge clk);
    apply(1'b0, 1'b1, 1'b0, 1'b1, 8'h99, 8'h66);
    drive_check(1'b0, 1'b1, 8'h3c);
  endtask
  // a second reset leaves storage untouched
  task t_noreset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    apply(1'b0, 1'b0, 1'b1, 1'b0, 8'h99, 8'h66);
    drive_check(1'b1, 1'b0, 8'h3c);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_live;
    t_store;
    t_gate;
    t_hold;
    t_noreset;
    close_out;
  end
  // whole run is about 53 cycles, so this is far beyond it
  initial
  begin
    #100us;
    errors++;
    close_out;
  end
endmodule
